// File: core/pcs_pkg.sv
package pcs_pkg;

  // Serial slave identity and framing
  localparam logic [6:0] PCS_SLAVE_ADDR = 7'h3e;
  localparam logic [3:0] PCS_LAST_BIT = 4'h8;
  localparam logic [3:0] PCS_FIRST_BIT = 4'h1;
  localparam logic [3:0] PCS_BIT_ZERO = 4'h0;

  // Register space layout
  localparam logic [7:0] PCS_RESERVED_IDX = 8'h00;
  localparam logic [7:0] PCS_SLEEP_REG_IDX = 8'h03;
  localparam int PCS_AWAKE_BIT = 0;
  localparam int PCS_REG_COUNT = 256;

  // Default load sequencing
  localparam logic [8:0] PCS_LOAD_ISSUE_END = 9'h100;
  localparam logic [8:0] PCS_LOAD_END = 9'h102;
  localparam logic [8:0] PCS_LOAD_START = 9'h000;

  // Clock rate of the control domain
  localparam int PCS_CLK_FREQ_MHZ = 20;

  // Pixel clock activity window: beat toggles every 1024 pixel clocks
  localparam int PCS_PIX_DIV_BITS = 10;
  localparam logic [9:0] PCS_PIX_DIV_LAST = 10'h3ff;
  localparam int PCS_PIX_IDLE_TIME_US = 100;
  localparam int PCS_PIX_IDLE_CYCLES = PCS_PIX_IDLE_TIME_US * PCS_CLK_FREQ_MHZ;
  localparam int PCS_PIX_CNT_W = 12;

  // Video presence hold, long enough to bridge vertical blanking
  localparam int PCS_VIDEO_HOLD_TIME_US = 25000;
  localparam int PCS_VID_CNT_W = 20;

  // Serial slave states
  typedef enum logic [3:0] {
    PCS_SER_IDLE = 4'h0,
    PCS_SER_ADDR = 4'h1,
    PCS_SER_ADDR_ACK = 4'h2,
    PCS_SER_INDEX = 4'h3,
    PCS_SER_INDEX_ACK = 4'h4,
    PCS_SER_WDATA = 4'h5,
    PCS_SER_WDATA_ACK = 4'h6,
    PCS_SER_RDATA = 4'h7,
    PCS_SER_RDATA_ACK = 4'h8,
    PCS_SER_SKIP = 4'h9
  } pcs_ser_state_type;

  // Default load states
  typedef enum logic [1:0] {
    PCS_LD_WAIT = 2'h0,
    PCS_LD_COPY = 2'h1,
    PCS_LD_DONE = 2'h2
  } pcs_load_state_type;

endpackage : pcs_pkg

// File: core/pcs_pixel_side.sv
`timescale 1ns/10ps
module pcs_pixel_side
  import pcs_pkg::*;
(
  // Pixel clock domain
  input wire logic pix_clk_i,
  input wire logic srst_i,
  // Video timing from pixel-domain logic
  input wire logic video_valid_i,
  // Slow levels for the control domain
  output logic beat_o,
  output logic video_seen_o
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [PCS_PIX_DIV_BITS-1:0] div_reg;
  logic seen_reg;

  // Reset brought into the pixel domain
  always_ff @(posedge pix_clk_i) begin
    rst_meta_reg <= srst_i;
    rst_sync_reg <= rst_meta_reg;
  end

  // Slow beat and windowed video presence, both safe to sample at 20 MHz
  always_ff @(posedge pix_clk_i) begin
    if (rst_sync_reg) begin
      div_reg <= '0;
      beat_o <= 1'b0;
      seen_reg <= 1'b0;
      video_seen_o <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      if (div_reg == PCS_PIX_DIV_LAST) begin
        beat_o <= ~beat_o;
        video_seen_o <= seen_reg | video_valid_i;
        seen_reg <= 1'b0;
      end else begin
        seen_reg <= seen_reg | video_valid_i;
      end
    end
  end

endmodule : pcs_pixel_side

// File: core/pcs_serial_slave.sv
`timescale 1ns/10ps
module pcs_serial_slave
  import pcs_pkg::*;
#(
  parameter int VIDEO_HOLD_CYCLES = PCS_VIDEO_HOLD_TIME_US * PCS_CLK_FREQ_MHZ
) (
  // Control clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pixel clock and video timing
  input wire logic pix_clk_i,
  input wire logic video_valid_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Panel pins and supply status
  input wire logic panel_reset_low_i,
  input wire logic analog_3v3_supply_ok_i,
  // Nonvolatile default storage
  output logic [7:0] nvm_addr_o,
  output logic nvm_rd_o,
  input wire logic [7:0] nvm_data_i,
  // Display control status
  output logic load_busy_o,
  output logic display_awake_bit_o,
  output logic display_enable_o,
  output logic video_accept_o
);

  // Configuration register space, kept across sleep
  logic [7:0] regs_mem [PCS_REG_COUNT];

  // Pin synchronisers and edge history
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic rstn_meta_reg;
  logic rstn_sync_reg;
  logic v33_meta_reg;
  logic v33_sync_reg;

  // Crossings from the pixel domain
  logic pix_beat;
  logic pix_video_seen;
  logic beat_meta_reg;
  logic beat_sync_reg;
  logic beat_prev_reg;
  logic vid_meta_reg;
  logic vid_sync_reg;
  logic [PCS_PIX_CNT_W-1:0] pix_idle_reg;
  logic [PCS_VID_CNT_W-1:0] vid_hold_reg;
  logic pix_active;
  logic video_ok;

  // Serial slave state
  pcs_ser_state_type ser_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] index_reg;
  logic rw_reg;
  logic nack_reg;
  logic sda_oe_reg;
  logic sda_out_reg;

  // Default load state
  pcs_load_state_type ld_state_reg;
  logic [8:0] ld_cnt_reg;
  logic [7:0] nvm_addr_reg;
  logic nvm_rd_reg;
  logic ld_wr_reg;
  logic [7:0] ld_wr_addr_reg;

  // Status flops
  logic display_enable_reg;
  logic video_accept_reg;
  logic load_busy_reg;
  logic awake_reg;

  // Decoded bus events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic serial_ready;
  logic ser_wr;
  logic ld_finish;
  logic [7:0] rd_byte;

  // Pixel clock side: slow beat and video presence
  pcs_pixel_side u_pixel_side (
    .pix_clk_i(pix_clk_i),
    .srst_i(srst_i),
    .video_valid_i(video_valid_i),
    .beat_o(pix_beat),
    .video_seen_o(pix_video_seen)
  );

  // Two-flop synchronisers for every pin and crossing level
  always_ff @(posedge clk_i) begin
    scl_meta_reg <= scl_i;
    scl_sync_reg <= scl_meta_reg;
    sda_meta_reg <= sda_i;
    sda_sync_reg <= sda_meta_reg;
    rstn_meta_reg <= panel_reset_low_i;
    rstn_sync_reg <= rstn_meta_reg;
    v33_meta_reg <= analog_3v3_supply_ok_i;
    v33_sync_reg <= v33_meta_reg;
    beat_meta_reg <= pix_beat;
    beat_sync_reg <= beat_meta_reg;
    vid_meta_reg <= pix_video_seen;
    vid_sync_reg <= vid_meta_reg;
  end

  // Edge history on synchronised levels only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      beat_prev_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_sync_reg;
      sda_prev_reg <= sda_sync_reg;
      beat_prev_reg <= beat_sync_reg;
    end
  end

  // Bus conditions, sampled at 20 MHz so any rate up to fast mode works
  assign scl_rise = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_sync_reg & scl_prev_reg;
  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg
                     & ~sda_sync_reg;
  assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg
                    & sda_sync_reg;

  // Pixel clock activity: beat must keep changing within the idle window
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pix_idle_reg <= '0;
    end else if (beat_sync_reg != beat_prev_reg) begin
      pix_idle_reg <= PCS_PIX_CNT_W'(PCS_PIX_IDLE_CYCLES);
    end else if (pix_idle_reg != '0) begin
      pix_idle_reg <= pix_idle_reg - 1'b1;
    end
  end

  assign pix_active = (pix_idle_reg != '0);

  // Valid video seen recently, held across blanking
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vid_hold_reg <= '0;
    end else if (vid_sync_reg) begin
      vid_hold_reg <= PCS_VID_CNT_W'(VIDEO_HOLD_CYCLES);
    end else if (vid_hold_reg != '0) begin
      vid_hold_reg <= vid_hold_reg - 1'b1;
    end
  end

  assign video_ok = (vid_hold_reg != '0);

  // Default load: wait for reset released and pixel clock, then copy
  always_ff @(posedge clk_i) begin
    if (srst_i || !rstn_sync_reg) begin
      ld_state_reg <= PCS_LD_WAIT;
      ld_cnt_reg <= PCS_LOAD_START;
      nvm_addr_reg <= '0;
      nvm_rd_reg <= 1'b0;
      ld_wr_reg <= 1'b0;
      ld_wr_addr_reg <= '0;
    end else begin
      ld_wr_reg <= nvm_rd_reg;
      ld_wr_addr_reg <= nvm_addr_reg;
      case (ld_state_reg)
        PCS_LD_WAIT: begin
          nvm_rd_reg <= 1'b0;
          if (pix_active) begin
            ld_state_reg <= PCS_LD_COPY;
            ld_cnt_reg <= PCS_LOAD_START;
          end
        end
        PCS_LD_COPY: begin
          nvm_addr_reg <= ld_cnt_reg[7:0];
          nvm_rd_reg <= (ld_cnt_reg < PCS_LOAD_ISSUE_END);
          ld_cnt_reg <= ld_cnt_reg + 1'b1;
          if (ld_cnt_reg == PCS_LOAD_END) begin
            ld_state_reg <= PCS_LD_DONE;
          end
        end
        PCS_LD_DONE: begin
          nvm_rd_reg <= 1'b0;
        end
        default: begin
          ld_state_reg <= PCS_LD_WAIT;
          nvm_rd_reg <= 1'b0;
        end
      endcase
    end
  end

  assign serial_ready = (ld_state_reg == PCS_LD_DONE);
  assign ld_finish = (ld_state_reg == PCS_LD_COPY)
                     && (ld_cnt_reg == PCS_LOAD_END);

  // Serial byte write strobe, taken on the fall that ends the eighth bit
  assign ser_wr = (ser_state_reg == PCS_SER_WDATA) && scl_fall
                  && (bit_cnt_reg == PCS_LAST_BIT) && !start_det
                  && !stop_det;

  // Register space writes; the reserved index stays read only
  always_ff @(posedge clk_i) begin
    if (ld_wr_reg) begin
      regs_mem[ld_wr_addr_reg] <= nvm_data_i;
    end else if (ld_finish) begin
      regs_mem[PCS_SLEEP_REG_IDX][PCS_AWAKE_BIT] <= 1'b0;
    end else if (ser_wr && index_reg != PCS_RESERVED_IDX) begin
      regs_mem[index_reg] <= shift_reg;
    end
  end

  assign rd_byte = regs_mem[index_reg];

  // Serial slave engine; SDA only changes while SCL is low
  always_ff @(posedge clk_i) begin
    if (srst_i || !serial_ready) begin
      ser_state_reg <= PCS_SER_IDLE;
      bit_cnt_reg <= PCS_BIT_ZERO;
      shift_reg <= '0;
      index_reg <= '0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      ser_state_reg <= PCS_SER_ADDR;
      bit_cnt_reg <= PCS_BIT_ZERO;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      ser_state_reg <= PCS_SER_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (ser_state_reg)
        PCS_SER_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        PCS_SER_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == PCS_LAST_BIT) begin
            bit_cnt_reg <= PCS_BIT_ZERO;
            if (shift_reg[7:1] == PCS_SLAVE_ADDR) begin
              rw_reg <= shift_reg[0];
              sda_oe_reg <= 1'b1;
              ser_state_reg <= PCS_SER_ADDR_ACK;
            end else begin
              ser_state_reg <= PCS_SER_SKIP;
            end
          end
        end
        PCS_SER_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              bit_cnt_reg <= PCS_FIRST_BIT;
              ser_state_reg <= PCS_SER_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              ser_state_reg <= PCS_SER_INDEX;
            end
          end
        end
        PCS_SER_INDEX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == PCS_LAST_BIT) begin
            index_reg <= shift_reg;
            bit_cnt_reg <= PCS_BIT_ZERO;
            sda_oe_reg <= 1'b1;
            ser_state_reg <= PCS_SER_INDEX_ACK;
          end
        end
        PCS_SER_INDEX_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            ser_state_reg <= PCS_SER_WDATA;
          end
        end
        PCS_SER_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == PCS_LAST_BIT) begin
            index_reg <= index_reg + 1'b1;
            bit_cnt_reg <= PCS_BIT_ZERO;
            sda_oe_reg <= 1'b1;
            ser_state_reg <= PCS_SER_WDATA_ACK;
          end
        end
        PCS_SER_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            ser_state_reg <= PCS_SER_WDATA;
          end
        end
        PCS_SER_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == PCS_LAST_BIT) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= PCS_BIT_ZERO;
              index_reg <= index_reg + 1'b1;
              ser_state_reg <= PCS_SER_RDATA_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
        end
        PCS_SER_RDATA_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_sync_reg;
          end else if (scl_fall) begin
            if (!nack_reg) begin
              shift_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              bit_cnt_reg <= PCS_FIRST_BIT;
              ser_state_reg <= PCS_SER_RDATA;
            end else begin
              ser_state_reg <= PCS_SER_SKIP;
            end
          end
        end
        PCS_SER_SKIP: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          ser_state_reg <= PCS_SER_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data pin: level held low, only the enable moves
  always_ff @(posedge clk_i) begin
    sda_out_reg <= 1'b0;
  end

  // Display control: awake bit gated by supply, clock and video
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      awake_reg <= 1'b0;
      load_busy_reg <= 1'b1;
      display_enable_reg <= 1'b0;
      video_accept_reg <= 1'b0;
    end else begin
      awake_reg <= serial_ready
                   & regs_mem[PCS_SLEEP_REG_IDX][PCS_AWAKE_BIT];
      load_busy_reg <= !serial_ready;
      display_enable_reg <= awake_reg & v33_sync_reg & pix_active
                            & video_ok;
      video_accept_reg <= awake_reg & v33_sync_reg & pix_active
                          & video_ok;
    end
  end

  // Outputs straight from flops
  assign sda_o = sda_out_reg;
  assign sda_oe_o = sda_oe_reg;
  assign nvm_addr_o = nvm_addr_reg;
  assign nvm_rd_o = nvm_rd_reg;
  assign load_busy_o = load_busy_reg;
  assign display_awake_bit_o = awake_reg;
  assign display_enable_o = display_enable_reg;
  assign video_accept_o = video_accept_reg;

endmodule : pcs_serial_slave

// File: testbench/pcs_serial_slave_assertions.sv
`timescale 1ns/10ps
module pcs_serial_slave_assertions
  import pcs_pkg::*;
#(
  parameter int VIDEO_HOLD_CYCLES = PCS_VIDEO_HOLD_TIME_US * PCS_CLK_FREQ_MHZ
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pix_clk_i,
  // Inputs of the slave
  input wire logic video_valid_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic panel_reset_low_i,
  input wire logic analog_3v3_supply_ok_i,
  input wire logic [7:0] nvm_data_i,
  // Outputs of the slave
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] nvm_addr_o,
  input wire logic nvm_rd_o,
  input wire logic load_busy_o,
  input wire logic display_awake_bit_o,
  input wire logic display_enable_o,
  input wire logic video_accept_o
);
  // Everything here lives in the control clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Bus stays untouched while defaults load
  load_quiet_a: assert property (load_busy_o |-> !sda_oe_o)
    else $error("slave drove SDA during default load");
  nvm_in_load_a: assert property (nvm_rd_o |-> load_busy_o)
    else $error("storage read outside default load");
  nvm_step_a: assert property (nvm_rd_o && $past(nvm_rd_o) |->
    nvm_addr_o == $past(nvm_addr_o) + 8'h01)
    else $error("storage address did not step by one");
  // SDA may only move while SCL is low, else it forms a start or stop
  sda_scl_low_a: assert property ($changed(sda_oe_o) |->
    !scl_i && !sda_o)
    else $error("slave changed SDA while SCL high");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("slave low drive shorter than a bit");
  awake_gate_a: assert property (!display_awake_bit_o [*3] |->
    !display_enable_o)
    else $error("display enabled while asleep");
  supply_gate_a: assert property (!analog_3v3_supply_ok_i [*6] |->
    !display_enable_o)
    else $error("display enabled without supply");
  accept_same_a: assert property (video_accept_o == display_enable_o)
    else $error("video accepted while display off");
  awake_cleared_a: assert property ($fell(load_busy_o) |->
    !display_awake_bit_o)
    else $error("awake bit set at end of load");
  busy_dark_a: assert property (load_busy_o |-> !display_enable_o)
    else $error("display enabled during default load");

  // Main scenarios reached
  ack_seen_c: cover property ($rose(sda_oe_o));
  load_done_c: cover property ($fell(load_busy_o));
  shown_c: cover property ($rose(display_enable_o));
endmodule : pcs_serial_slave_assertions

bind pcs_serial_slave pcs_serial_slave_assertions #(
  .VIDEO_HOLD_CYCLES(VIDEO_HOLD_CYCLES)
) u_pcs_serial_slave_assertions (
  .clk_i(clk_i), .srst_i(srst_i), .pix_clk_i(pix_clk_i),
  .video_valid_i(video_valid_i), .scl_i(scl_i), .sda_i(sda_i),
  .panel_reset_low_i(panel_reset_low_i),
  .analog_3v3_supply_ok_i(analog_3v3_supply_ok_i),
  .nvm_data_i(nvm_data_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .nvm_addr_o(nvm_addr_o), .nvm_rd_o(nvm_rd_o), .load_busy_o(load_busy_o),
  .display_awake_bit_o(display_awake_bit_o),
  .display_enable_o(display_enable_o), .video_accept_o(video_accept_o)
);

// File: testbench/pcs_host_model.sv
`timescale 1ns/10ps
module pcs_host_model (
  // Pacing clock
  input wire logic clk_i,
  // Bus wire level
  input wire logic sda_i,
  // Master drive
  output logic scl_o,
  output logic sda_oe_o
);
  int unsigned half_cyc = 10;

  // Bus free: both lines released high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic hold(input int unsigned n);
    repeat (n) @(negedge clk_i);
  endtask : hold

  // One bit: data set mid-low, sampled at end of high
  task automatic bit_x(input logic b, output logic s);
    hold(half_cyc / 2);
    sda_oe_o = !b;
    hold(half_cyc - half_cyc / 2);
    scl_o = 1'b1;
    hold(half_cyc);
    s = sda_i;
    scl_o = 1'b0;
  endtask : bit_x

  // Start or repeated start
  task automatic bus_start();
    hold(half_cyc / 2);
    sda_oe_o = 1'b0;
    hold(half_cyc / 2);
    scl_o = 1'b1;
    hold(half_cyc);
    sda_oe_o = 1'b1;
    hold(half_cyc);
    scl_o = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    hold(half_cyc / 2);
    sda_oe_o = 1'b1;
    hold(half_cyc / 2);
    scl_o = 1'b1;
    hold(half_cyc);
    sda_oe_o = 1'b0;
    hold(half_cyc);
  endtask : bus_stop

  // Byte out MSB first, then the receiver's acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, ack);
  endtask : send_byte

  // Byte in; master acknowledges all but the last
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, s);
  endtask : recv_byte
endmodule : pcs_host_model

// File: testbench/pcs_serial_slave_tb.sv
`timescale 1ns/10ps
module pcs_serial_slave_tb;
  import pcs_pkg::*;
  localparam int HOLD = 2000;
  localparam int SHUTDOWN_HOLD_CYC = 1500 * PCS_CLK_FREQ_MHZ;
  localparam logic [7:0] WR_ADDR = {PCS_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RD_ADDR = {PCS_SLAVE_ADDR, 1'b1};
  logic clk_i, srst_i, pix_clk_i, pix_run, video_valid_i, scl_w, host_oe;
  logic panel_reset_low_i, analog_3v3_supply_ok_i, sda_o, sda_oe_o;
  logic nvm_rd_o, load_busy_o, display_awake_bit_o;
  logic display_enable_o, video_accept_o;
  logic [7:0] nvm_addr_o, nvm_data_i;
  wire logic sda_w;
  int bad_count = 0;
  int total_checks = 0;
  int rd_pulses = 0;

  // Open-drain wire with pull-up
  assign sda_w = !((sda_oe_o && !sda_o) || host_oe);

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Pixel clock, free phase, held low while stopped
  initial begin
    pix_clk_i = 1'b0;
    #1.7;
    forever #3 pix_clk_i = pix_run ? ~pix_clk_i : 1'b0;
  end
  // Default storage: byte k holds k ^ 5a, one cycle latency
  always @(posedge clk_i) begin
    nvm_data_i <= nvm_addr_o ^ 8'h5a;
    if (nvm_rd_o === 1'b1) rd_pulses <= rd_pulses + 1;
  end

  pcs_serial_slave #(.VIDEO_HOLD_CYCLES(HOLD)) u_pcs_serial_slave (
    .clk_i(clk_i), .srst_i(srst_i), .pix_clk_i(pix_clk_i),
    .video_valid_i(video_valid_i), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .panel_reset_low_i(panel_reset_low_i),
    .analog_3v3_supply_ok_i(analog_3v3_supply_ok_i),
    .nvm_addr_o(nvm_addr_o), .nvm_rd_o(nvm_rd_o), .nvm_data_i(nvm_data_i),
    .load_busy_o(load_busy_o), .display_awake_bit_o(display_awake_bit_o),
    .display_enable_o(display_enable_o), .video_accept_o(video_accept_o)
  );
  pcs_host_model u_pcs_host_model (
    .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(host_oe)
  );

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic give_up();
    bad_count++;
    end_of_test();
  endtask : give_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Start plus address byte; exp_ack is the expected wire level
  task automatic sel(input logic [7:0] a, input logic exp_ack);
    logic ack;
    u_pcs_host_model.bus_start();
    u_pcs_host_model.send_byte(a, ack);
    check(16'(ack), 16'(exp_ack));
  endtask : sel

  task automatic wr_regs(input logic [7:0] idx, input logic [7:0] d[$]);
    logic ack;
    sel(WR_ADDR, 1'b0);
    u_pcs_host_model.send_byte(idx, ack);
    check(16'(ack), 16'h0);
    foreach (d[i]) begin
      u_pcs_host_model.send_byte(d[i], ack);
      check(16'(ack), 16'h0);
    end
    u_pcs_host_model.bus_stop();
  endtask : wr_regs

  task automatic rd_regs(input logic [7:0] idx, input logic [7:0] exp[$]);
    logic ack;
    logic [7:0] got;
    sel(WR_ADDR, 1'b0);
    u_pcs_host_model.send_byte(idx, ack);
    check(16'(ack), 16'h0);
    sel(RD_ADDR, 1'b0);
    foreach (exp[i]) begin
      u_pcs_host_model.recv_byte(i == exp.size() - 1, got);
      check(16'(got), 16'(exp[i]));
    end
    u_pcs_host_model.bus_stop();
  endtask : rd_regs

  // Traffic during the default load is ignored, then defaults read back
  task automatic t_load();
    sel(WR_ADDR, 1'b1);
    u_pcs_host_model.bus_stop();
    for (int n = 0; load_busy_o !== 1'b0; n++) begin
      if (n > 3000) give_up();
      @(negedge clk_i);
    end
    check(16'(rd_pulses), 16'h0100);
    check(16'(display_awake_bit_o), 16'h0);
    check(16'(display_enable_o), 16'h0);
    rd_regs(8'h20, '{8'h7a, 8'h7b});
  endtask : t_load

  // Burst write wrapping past the top index, faster read back
  task automatic t_multi();
    wr_regs(8'hfe, '{8'ha5, 8'h3c, 8'hc3});
    u_pcs_host_model.half_cyc = 6;
    rd_regs(8'hfe, '{8'ha5, 8'h3c});
    rd_regs(8'hff, '{8'h3c, 8'h5a, 8'h5b});
    u_pcs_host_model.half_cyc = 10;
  endtask : t_multi

  // Every single-bit address error is ignored up to the next start
  task automatic t_foreign();
    logic ack;
    for (int b = 0; b < 7; b++) begin
      sel({PCS_SLAVE_ADDR ^ (7'h01 << b), 1'b0}, 1'b1);
      if (b == 0) u_pcs_host_model.send_byte(8'h00, ack);
      if (b == 0) check(16'(ack), 16'h1);
      u_pcs_host_model.bus_stop();
    end
    rd_regs(8'h20, '{8'h7a});
  endtask : t_foreign

  // Wake with clock stopped, gate on supply, then sleep and retain
  task automatic t_display();
    @(negedge clk_i);
    pix_run = 1'b0;
    analog_3v3_supply_ok_i = 1'b0;
    repeat (2200) @(negedge clk_i);
    wr_regs(PCS_SLEEP_REG_IDX, '{8'h01});
    check(16'(display_awake_bit_o), 16'h1);
    check(16'(display_enable_o), 16'h0);
    pix_run = 1'b1;
    video_valid_i = 1'b1;
    repeat (600) @(negedge clk_i);
    check(16'(display_enable_o), 16'h0);
    analog_3v3_supply_ok_i = 1'b1;
    for (int n = 0; display_enable_o !== 1'b1; n++) begin
      if (n > 1500) give_up();
      @(negedge clk_i);
    end
    check(16'(video_accept_o), 16'h1);
    wr_regs(PCS_SLEEP_REG_IDX, '{8'h00});
    repeat (4) @(negedge clk_i);
    check(16'(display_enable_o), 16'h0);
    check(16'(video_accept_o), 16'h0);
    rd_regs(8'hfe, '{8'ha5});
    repeat (SHUTDOWN_HOLD_CYC) @(negedge clk_i);
    analog_3v3_supply_ok_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check(16'(display_enable_o), 16'h0);
  endtask : t_display

  // Panel reset mid-run restarts the default load and drops written data
  task automatic t_reload();
    @(negedge clk_i);
    panel_reset_low_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check(16'(load_busy_o), 16'h1);
    sel(WR_ADDR, 1'b1);
    u_pcs_host_model.bus_stop();
    panel_reset_low_i = 1'b1;
    for (int n = 0; load_busy_o !== 1'b0; n++) begin
      if (n > 3000) give_up();
      @(negedge clk_i);
    end
    check(16'(display_awake_bit_o), 16'h0);
    rd_regs(8'hfe, '{8'ha4});
  endtask : t_reload

  initial begin
    repeat (90000) @(negedge clk_i);
    give_up();
  end

  initial begin
    srst_i = 1'b1;
    pix_run = 1'b1;
    video_valid_i = 1'b0;
    panel_reset_low_i = 1'b1;
    analog_3v3_supply_ok_i = 1'b1;
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    t_load();
    t_multi();
    t_foreign();
    t_display();
    t_reload();
    end_of_test();
  end
endmodule : pcs_serial_slave_tb
